// ---- include/pcp_pkg.sv ----
package pcp_pkg;
  typedef enum logic [1:0] {AUTO_OFF, AUTO_ONCE, AUTO_CONT} pcp_auto_type;
  localparam logic [1:0] CH_GREEN = 2'h0;
  localparam logic [1:0] CH_RED = 2'h1;
  localparam logic [1:0] CH_BLUE = 2'h2;
  localparam logic [1:0] GSEL_ALL = 2'h0;
  localparam logic [1:0] MODE_CODE_BAD = 2'h3;
  localparam logic [5:0] GAIN_DB_MAX = 6'h2F;
  localparam logic [5:0] GAIN_DB_RST = 6'h00;
  localparam int GAIN_DB_PER_OCT = 6;
  localparam int GAIN_FRAC = 8;
  localparam logic [15:0] GAIN_UNITY = 16'h0100;
  localparam logic [8:0] BLK_FULL = 9'h190;
  localparam logic [8:0] BLK_ANA_MAX = 9'h028;
  localparam logic [8:0] BLK_RST = 9'h000;
  localparam int PCT_MUL = 41;
  localparam int PCT_SHIFT = 14;
  localparam int RATIO_FRAC = 8;
  localparam logic [11:0] RATIO_ONE = 12'h100;
  localparam logic [11:0] RATIO_STEP = 12'h002;
  localparam logic [11:0] RATIO_MIN = 12'h010;
  localparam logic [11:0] RATIO_MAX = 12'hFF0;
  localparam logic WB_SEL_RED = 1'b0;
  localparam logic [3:0] WB_ITER = 4'h8;
  localparam int WB_TOL_SHIFT = 5;
  localparam int WB_G_SHIFT = 1;
  localparam int ACC_W = 34;
  localparam int LOG_FRAC = 8;
  localparam logic signed [8:0] SH_AMT_RST = 9'sh020;
  localparam logic signed [8:0] SH_AMT_MIN = -9'sh010;
  localparam logic signed [8:0] SH_AMT_MAX = 9'sh080;
  localparam int SH_AMT_FRAC = 4;
  localparam logic [7:0] SH_THR_MAX = 8'h40;
  localparam int SH_THR_FRAC = 8;
  localparam int SH_NOISE_SHIFT = 4;
  localparam int SH_PRIME = 2;

  // Returns {red ratio, blue ratio} for an illuminant preset
  function automatic logic [23:0] pcp_preset_ratios(input logic [1:0] p);
    unique case (p)
      2'h0: return {12'h180, 12'h1A0};
      2'h1: return {12'h100, 12'h2C0};
      2'h2: return {12'h140, 12'h200};
      2'h3: return {12'h160, 12'h1C0};
    endcase
  endfunction : pcp_preset_ratios

  // Decibels to linear gain, 8 fraction bits; 6 dB is taken as one octave
  function automatic logic [15:0] pcp_gain_lin(input logic [5:0] db);
    logic [15:0] m;
    m = 16'h0100;
    unique case (db % 6'(GAIN_DB_PER_OCT))
      6'h00: m = 16'h0100;
      6'h01: m = 16'h011F;
      6'h02: m = 16'h0142;
      6'h03: m = 16'h016A;
      6'h04: m = 16'h0196;
      6'h05: m = 16'h01C8;
      default: m = 16'h0100;
    endcase
    return m << (db / 6'(GAIN_DB_PER_OCT));
  endfunction : pcp_gain_lin
endpackage : pcp_pkg

// ---- rtl/pcp_lut_mem.sv ----
module pcp_lut_mem #(
  parameter int AW = 12,
  parameter int DW = 12
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  // Contents are not reset; software loads the table before enabling it
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rd_data_o <= '0;
    else
      rd_data_o <= mem[rd_addr_i];
  end
endmodule : pcp_lut_mem

// ---- rtl/pcp_sharpen.sv ----
module pcp_sharpen #(
  parameter int PIX_W = 12
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic valid_i,
  input wire logic [PIX_W-1:0] pix_i,
  input wire logic [1:0] chan_i,
  input wire logic en_i,
  input wire logic signed [8:0] amt_i,
  input wire logic [PIX_W-1:0] thr_i,
  output logic [PIX_W-1:0] pix_o,
  output logic valid_o,
  output logic [1:0] chan_o,
  output logic [PIX_W-1:0] absd_o
);
  localparam int DW = PIX_W + 3;
  localparam int CW = DW + 9;
  localparam logic [PIX_W-1:0] PIX_MAX = '1;
  logic [PIX_W-1:0] x0;
  logic [PIX_W-1:0] x1;
  logic [1:0] c1;
  logic [1:0] fill;

  // Three-tap window in stream order: x0 left, x1 centre, pix_i right
  wire primed = fill == 2'(pcp_pkg::SH_PRIME);
  wire signed [DW-1:0] d = DW'({x1, 1'b0}) - DW'(x0) - DW'(pix_i);
  wire signed [DW-1:0] hd = d >>> 1;
  wire [DW-1:0] absd = hd[DW-1] ? DW'(-hd) : DW'(hd);
  wire edge_hit = en_i && (absd > DW'(thr_i));
  wire signed [CW-1:0] corr = (CW'(amt_i) * CW'(hd)) >>> pcp_pkg::SH_AMT_FRAC;
  wire signed [CW-1:0] ysum = CW'(signed'({1'b0, x1})) + corr;
  wire [PIX_W-1:0] ysat = ysum[CW-1] ? '0 :
    (ysum > CW'(PIX_MAX) ? PIX_MAX : ysum[PIX_W-1:0]);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      x0 <= '0;
      x1 <= '0;
      c1 <= '0;
      fill <= '0;
      pix_o <= '0;
      valid_o <= 1'b0;
      chan_o <= '0;
      absd_o <= '0;
    end
    else
    begin
      valid_o <= valid_i && primed;
      if (valid_i)
      begin
        x0 <= x1;
        x1 <= pix_i;
        c1 <= chan_i;
        fill <= primed ? fill : fill + 2'h1;
        pix_o <= edge_hit ? ysat : x1;
        chan_o <= c1;
        absd_o <= (absd > DW'(PIX_MAX)) ? PIX_MAX : absd[PIX_W-1:0];
      end
    end
  end
endmodule : pcp_sharpen

// ---- rtl/pcp_pipeline.sv ----
module pcp_pipeline #(
  parameter int PIX_W = 12
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [PIX_W-1:0] pix_i,
  input wire logic pix_valid_i,
  input wire logic [1:0] pix_chan_i,
  input wire logic frame_end_i,
  input wire logic [1:0] gain_sel_i,
  input wire logic gain_wr_i,
  input wire logic [5:0] gain_db_i,
  input wire logic ag_mode_wr_i,
  input wire logic [1:0] auto_amplification_mode_i,
  input wire logic blk_wr_i,
  input wire logic [8:0] blk_total_i,
  input wire logic wb_wr_i,
  input wire logic wb_sel_i,
  input wire logic [11:0] wb_ratio_i,
  input wire logic wb_mode_wr_i,
  input wire logic [1:0] wb_mode_i,
  input wire logic preset_wr_i,
  input wire logic [1:0] illuminant_preset_i,
  input wire logic power_curve_on_i,
  input wire logic [9:0] gamma_i,
  input wire logic pixel_lookup_stage_on_i,
  input wire logic lut_wr_i,
  input wire logic [PIX_W-1:0] lut_addr_i,
  input wire logic [PIX_W-1:0] lut_data_i,
  input wire logic sharp_en_wr_i,
  input wire logic sharp_en_i,
  input wire logic sharp_auto_i,
  input wire logic [7:0] sharp_thr_i,
  input wire logic sharp_amt_wr_i,
  input wire logic signed [8:0] sharp_amt_i,
  output logic [PIX_W-1:0] pix_o,
  output logic pix_valid_o,
  output logic [1:0] pix_chan_o,
  output logic [5:0] gain_db_o,
  output logic [1:0] auto_amplification_mode_o,
  output logic [8:0] blk_analog_o,
  output logic [8:0] blk_digital_o,
  output logic [8:0] blk_total_o,
  output logic [11:0] wb_red_o,
  output logic [11:0] wb_blue_o,
  output logic [1:0] wb_mode_o,
  output logic [1:0] ccm_sel_o,
  output logic sharp_en_o,
  output logic [7:0] sharp_thr_o,
  output logic signed [8:0] sharp_amt_o
);
  localparam int SW = PIX_W + 16;
  localparam logic [PIX_W-1:0] PIX_MAX = '1;

  if (PIX_W < 8 || PIX_W > 16)
    $error("pcp_pipeline: PIX_W must lie between 8 and 16");

  function automatic logic [PIX_W-1:0] sat(input logic [SW-1:0] x);
    return (x > SW'(PIX_MAX)) ? PIX_MAX : x[PIX_W-1:0];
  endfunction : sat

  // Power law through a piecewise-linear log2/exp2 pair; error stays under
  // a few percent, traded against a multiplier-only datapath
  function automatic logic [PIX_W-1:0] pow_curve(input logic [PIX_W-1:0] p,
                                                 input logic [9:0] g);
    logic [4:0] e;
    logic [PIX_W+7:0] nrm;
    logic [12:0] lmag;
    logic [22:0] y;
    logic [PIX_W+9:0] r;
    e = '0;
    for (int i = 0; i < PIX_W; i++)
    begin
      if (p[i])
        e = 5'(i);
    end
    nrm = {p, 8'h00} >> e;
    lmag = 13'(PIX_W * 256) - {e, nrm[pcp_pkg::LOG_FRAC-1:0]};
    y = 23'(lmag) * 23'(g);
    r = {10'h200 - {2'b00, y[15:8]}, PIX_W'(0)} >> 9;
    r = r >> y[22:16];
    if (p == '0 || y[22:16] >= 7'(PIX_W))
      return '0;
    return sat(SW'(r));
  endfunction : pow_curve

  localparam int AW = pcp_pkg::ACC_W;

  function automatic logic [11:0] step_ratio(input logic [11:0] r, input logic up,
                                            input logic dn);
    if (up && r <= pcp_pkg::RATIO_MAX - pcp_pkg::RATIO_STEP)
      return r + pcp_pkg::RATIO_STEP;
    if (dn && r >= pcp_pkg::RATIO_MIN + pcp_pkg::RATIO_STEP)
      return r - pcp_pkg::RATIO_STEP;
    return r;
  endfunction : step_ratio

  pcp_pkg::pcp_auto_type ag_mode;
  pcp_pkg::pcp_auto_type wb_mode;
  logic [5:0] gain_db;
  logic [8:0] blk_ana;
  logic [8:0] blk_dig;
  logic [11:0] wb_red;
  logic [11:0] wb_blue;
  logic [1:0] ccm_sel;
  logic [3:0] wb_iter;
  logic sharp_en;
  logic signed [8:0] sharp_amt;
  logic [PIX_W-1:0] peak;
  logic [pcp_pkg::ACC_W-1:0] sum_r;
  logic [pcp_pkg::ACC_W-1:0] sum_g;
  logic [pcp_pkg::ACC_W-1:0] sum_b;
  logic [PIX_W-1:0] noise;
  logic [PIX_W-1:0] p1;
  logic [PIX_W-1:0] p2;
  logic [PIX_W-1:0] p3;
  logic [PIX_W-1:0] p4;
  logic [1:0] c1;
  logic [1:0] c2;
  logic [1:0] c3;
  logic [1:0] c4;
  logic v1;
  logic v2;
  logic v3;
  logic v4;
  logic fe1;
  logic fe2;
  logic [PIX_W-1:0] lut_rd;
  logic [PIX_W-1:0] sh_absd;

  // Stage 1: gain then digital black offset
  wire gain_hit = gain_sel_i == pcp_pkg::GSEL_ALL || gain_sel_i == pix_chan_i + 2'h1;
  wire [15:0] glin = gain_hit ? pcp_pkg::pcp_gain_lin(gain_db) : pcp_pkg::GAIN_UNITY;
  wire [PIX_W+15:0] gprod = (PIX_W+16)'(pix_i) * (PIX_W+16)'(glin);
  wire [PIX_W+14:0] dig_prod = (PIX_W+15)'(blk_dig) * (PIX_W+15)'(PIX_MAX)
    * (PIX_W+15)'(pcp_pkg::PCT_MUL);
  wire [PIX_W-1:0] dig_code = dig_prod[pcp_pkg::PCT_SHIFT +: PIX_W];
  wire [PIX_W-1:0] next_p1 = sat(SW'(gprod[PIX_W+15:pcp_pkg::GAIN_FRAC])
    + SW'(dig_code));

  // Black level split: analog share first, the rest digital
  wire [8:0] blk_req = blk_total_i > pcp_pkg::BLK_FULL ? pcp_pkg::BLK_FULL : blk_total_i;
  wire [8:0] next_ana = blk_req > pcp_pkg::BLK_ANA_MAX ? pcp_pkg::BLK_ANA_MAX : blk_req;

  // Stage 2: white balance against green
  wire [11:0] ratio = c1 == pcp_pkg::CH_RED ? wb_red :
    (c1 == pcp_pkg::CH_BLUE ? wb_blue : pcp_pkg::RATIO_ONE);
  wire [PIX_W+11:0] wprod = (PIX_W+12)'(p1) * (PIX_W+12)'(ratio);
  wire [PIX_W-1:0] next_p2 = sat(SW'(wprod[PIX_W+11:pcp_pkg::RATIO_FRAC]));

  // Stage 3: optional power curve
  wire [PIX_W-1:0] next_p3 = power_curve_on_i ? pow_curve(p2, gamma_i) : p2;

  // Stage 4: lookup reads the gamma result, so the curve always comes first
  wire [PIX_W-1:0] p4_sel = pixel_lookup_stage_on_i ? lut_rd : p4;

  // Automatic gain: peak of stage 1 over the frame
  wire [PIX_W-1:0] next_peak = (v1 && p1 > peak) ? p1 : peak;
  wire ag_run = ag_mode != pcp_pkg::AUTO_OFF;
  wire ag_up = next_peak < (PIX_MAX >> 1) && gain_db < pcp_pkg::GAIN_DB_MAX;
  wire ag_dn = next_peak == PIX_MAX && gain_db != '0;
  wire [1:0] ag_code = auto_amplification_mode_i == pcp_pkg::MODE_CODE_BAD ? 2'h0
    : auto_amplification_mode_i;

  // Automatic balance: grey world on stage 2 sums; green weighted for two
  // green sites per red and blue, so other mosaics need a different shift
  wire [AW-1:0] tot_r = sum_r + ((v2 && c2 == pcp_pkg::CH_RED) ? AW'(p2) : '0);
  wire [AW-1:0] tot_g = sum_g + ((v2 && c2 == pcp_pkg::CH_GREEN) ? AW'(p2) : '0);
  wire [AW-1:0] tot_b = sum_b + ((v2 && c2 == pcp_pkg::CH_BLUE) ? AW'(p2) : '0);
  wire [AW-1:0] wr_s = tot_r << pcp_pkg::WB_G_SHIFT;
  wire [AW-1:0] wb_s = tot_b << pcp_pkg::WB_G_SHIFT;
  wire [AW-1:0] tol = tot_g >> pcp_pkg::WB_TOL_SHIFT;
  wire r_up = wr_s + tol < tot_g;
  wire r_dn = wr_s > tot_g + tol;
  wire b_up = wb_s + tol < tot_g;
  wire b_dn = wb_s > tot_g + tol;
  wire wb_run = wb_mode != pcp_pkg::AUTO_OFF;
  wire wb_adj = fe2 && wb_run;
  wire [1:0] wb_code = wb_mode_i == pcp_pkg::MODE_CODE_BAD ? 2'h0 : wb_mode_i;
  wire [23:0] preset = pcp_pkg::pcp_preset_ratios(illuminant_preset_i);

  // Sharpening threshold, as a pixel code
  wire [7:0] thr_man = sharp_thr_i > pcp_pkg::SH_THR_MAX ? pcp_pkg::SH_THR_MAX
    : sharp_thr_i;
  wire [PIX_W+7:0] thr_prod = (PIX_W+8)'(thr_man) * (PIX_W+8)'(PIX_MAX);
  wire [PIX_W-1:0] thr_quarter = PIX_MAX >> 2;
  wire [PIX_W:0] noise2 = {noise, 1'b0};
  wire [PIX_W-1:0] thr_auto = noise2 > (PIX_W+1)'(thr_quarter) ? thr_quarter
    : noise2[PIX_W-1:0];
  wire [PIX_W-1:0] thr_code = sharp_auto_i ? thr_auto
    : thr_prod[PIX_W+7:pcp_pkg::SH_THR_FRAC];
  wire [PIX_W-1:0] next_noise = noise - (noise >> pcp_pkg::SH_NOISE_SHIFT)
    + (sh_absd >> pcp_pkg::SH_NOISE_SHIFT);
  wire [PIX_W-1:0] thr_frac_auto = thr_auto >> (PIX_W - pcp_pkg::SH_THR_FRAC);
  wire signed [8:0] amt_req = sharp_amt_i < pcp_pkg::SH_AMT_MIN ? pcp_pkg::SH_AMT_MIN :
    (sharp_amt_i > pcp_pkg::SH_AMT_MAX ? pcp_pkg::SH_AMT_MAX : sharp_amt_i);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      {p1, p2, p3, p4} <= '0;
      {c1, c2, c3, c4} <= '0;
      {v1, v2, v3, v4, fe1, fe2} <= '0;
    end
    else
    begin
      {v1, v2, v3, v4} <= {pix_valid_i, v1, v2, v3};
      {c1, c2, c3, c4} <= {pix_chan_i, c1, c2, c3};
      {fe1, fe2} <= {frame_end_i, fe1};
      p1 <= next_p1;
      p2 <= next_p2;
      p3 <= next_p3;
      p4 <= p3;
    end
  end

  // Gain mode: a host write wins over the return to manual
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ag_mode <= pcp_pkg::AUTO_OFF;
      gain_db <= pcp_pkg::GAIN_DB_RST;
      peak <= '0;
    end
    else
    begin
      peak <= fe1 ? '0 : next_peak;
      if (ag_mode_wr_i)
        ag_mode <= pcp_pkg::pcp_auto_type'(ag_code);
      else if (fe1 && ag_mode == pcp_pkg::AUTO_ONCE)
        ag_mode <= pcp_pkg::AUTO_OFF;
      if (!ag_run && gain_wr_i)
        gain_db <= gain_db_i > pcp_pkg::GAIN_DB_MAX ? pcp_pkg::GAIN_DB_MAX : gain_db_i;
      else if (ag_run && fe1)
        gain_db <= ag_up ? gain_db + 6'h01 : (ag_dn ? gain_db - 6'h01 : gain_db);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      blk_ana <= pcp_pkg::BLK_RST;
      blk_dig <= pcp_pkg::BLK_RST;
    end
    else if (blk_wr_i)
    begin
      blk_ana <= next_ana;
      blk_dig <= blk_req - next_ana;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wb_mode <= pcp_pkg::AUTO_OFF;
      wb_red <= pcp_pkg::RATIO_ONE;
      wb_blue <= pcp_pkg::RATIO_ONE;
      wb_iter <= '0;
      ccm_sel <= '0;
      {sum_r, sum_g, sum_b} <= '0;
    end
    else
    begin
      sum_r <= fe2 ? '0 : tot_r;
      sum_g <= fe2 ? '0 : tot_g;
      sum_b <= fe2 ? '0 : tot_b;
      wb_iter <= wb_mode_wr_i ? '0 : (wb_adj ? wb_iter + 4'h1 : wb_iter);
      if (wb_mode_wr_i)
        wb_mode <= pcp_pkg::pcp_auto_type'(wb_code);
      else if (wb_adj && wb_mode == pcp_pkg::AUTO_ONCE && wb_iter == pcp_pkg::WB_ITER - 4'h1)
        wb_mode <= pcp_pkg::AUTO_OFF;
      if (preset_wr_i)
      begin
        {wb_red, wb_blue} <= preset;
        ccm_sel <= illuminant_preset_i;
      end
      else if (wb_wr_i && !wb_run)
      begin
        if (wb_sel_i == pcp_pkg::WB_SEL_RED)
          wb_red <= wb_ratio_i;
        else
          wb_blue <= wb_ratio_i;
      end
      else if (wb_adj)
      begin
        wb_red <= step_ratio(wb_red, r_up, r_dn);
        wb_blue <= step_ratio(wb_blue, b_up, b_dn);
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sharp_en <= 1'b0;
      sharp_amt <= pcp_pkg::SH_AMT_RST;
      noise <= '0;
    end
    else
    begin
      if (sharp_en_wr_i)
        sharp_en <= sharp_en_i;
      if (sharp_amt_wr_i)
        sharp_amt <= amt_req;
      if (pix_valid_o)
        noise <= next_noise;
    end
  end

  pcp_lut_mem #(
    .AW(PIX_W),
    .DW(PIX_W)
  ) u_lut (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_en_i(lut_wr_i),
    .wr_addr_i(lut_addr_i),
    .wr_data_i(lut_data_i),
    .rd_addr_i(p3),
    .rd_data_o(lut_rd)
  );

  pcp_sharpen #(
    .PIX_W(PIX_W)
  ) u_sharpen (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .valid_i(v4),
    .pix_i(p4_sel),
    .chan_i(c4),
    .en_i(sharp_en),
    .amt_i(sharp_amt),
    .thr_i(thr_code),
    .pix_o(pix_o),
    .valid_o(pix_valid_o),
    .chan_o(pix_chan_o),
    .absd_o(sh_absd)
  );

  assign gain_db_o = gain_db;
  assign auto_amplification_mode_o = ag_mode;
  assign blk_analog_o = blk_ana;
  assign blk_digital_o = blk_dig;
  assign blk_total_o = blk_ana + blk_dig;
  assign wb_red_o = wb_red;
  assign wb_blue_o = wb_blue;
  assign wb_mode_o = wb_mode;
  assign ccm_sel_o = ccm_sel;
  assign sharp_en_o = sharp_en;
  assign sharp_thr_o = sharp_auto_i ? thr_frac_auto[7:0] : thr_man;
  assign sharp_amt_o = sharp_amt;
endmodule : pcp_pipeline

// ---- bench/pcp_checker_assertions.sv ----
module pcp_checker (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic frame_end_i,
  input wire logic gain_wr_i,
  input wire logic [5:0] gain_db_i,
  input wire logic ag_mode_wr_i,
  input wire logic blk_wr_i,
  input wire logic [8:0] blk_total_i,
  input wire logic wb_wr_i,
  input wire logic wb_sel_i,
  input wire logic [11:0] wb_ratio_i,
  input wire logic wb_mode_wr_i,
  input wire logic preset_wr_i,
  input wire logic [1:0] illuminant_preset_i,
  input wire logic sharp_auto_i,
  input wire logic [7:0] sharp_thr_i,
  input wire logic sharp_amt_wr_i,
  input wire logic signed [8:0] sharp_amt_i,
  input wire logic [5:0] gain_db_o,
  input wire logic [1:0] auto_amplification_mode_o,
  input wire logic [8:0] blk_analog_o,
  input wire logic [8:0] blk_digital_o,
  input wire logic [8:0] blk_total_o,
  input wire logic [11:0] wb_red_o,
  input wire logic [1:0] wb_mode_o,
  input wire logic [1:0] ccm_sel_o,
  input wire logic [7:0] sharp_thr_o,
  input wire logic signed [8:0] sharp_amt_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  a_gain_manual: assert property ((gain_wr_i && !ag_mode_wr_i && gain_db_i <= 6'h2f
    && auto_amplification_mode_o == 2'h0) |=> gain_db_o == $past(gain_db_i))
    else $error("manual gain not taken");
  a_once_reverts: assert property ((auto_amplification_mode_o == 2'h1 && frame_end_i)
    |-> ##[1:4] auto_amplification_mode_o == 2'h0) else $error("gain once did not revert");
  a_blk_small: assert property ((blk_wr_i && blk_total_i <= 9'h028) |=>
    blk_analog_o == $past(blk_total_i) && blk_digital_o == 9'h000) else $error("black split");
  a_blk_sum: assert property ((blk_wr_i && blk_total_i <= 9'h190) |=>
    blk_total_o == $past(blk_total_i)) else $error("black total not read back");
  a_wb_manual: assert property ((wb_wr_i && !preset_wr_i && !wb_mode_wr_i && !wb_sel_i
    && wb_mode_o == 2'h0 && wb_ratio_i >= 12'h010 && wb_ratio_i <= 12'hff0)
    |=> wb_red_o == $past(wb_ratio_i)) else $error("red ratio not taken");
  a_preset_ccm: assert property (preset_wr_i |=> ccm_sel_o == $past(illuminant_preset_i))
    else $error("colour matrix not switched");
  a_thr_cap: assert property (sharp_thr_o <= 8'h40) else $error("threshold above quarter");
  a_thr_manual: assert property (!sharp_auto_i |->
    sharp_thr_o == ((sharp_thr_i > 8'h40) ? 8'h40 : sharp_thr_i)) else $error("threshold");
  a_amt_clamp: assert property (sharp_amt_wr_i |=> sharp_amt_o ==
    (($past(sharp_amt_i) < -9'sh010) ? -9'sh010 :
    ($past(sharp_amt_i) > 9'sh080) ? 9'sh080 : $past(sharp_amt_i))) else $error("amount");
  c_preset: cover property (preset_wr_i);
  c_once: cover property (auto_amplification_mode_o == 2'h1 && frame_end_i);
  c_smooth: cover property (sharp_amt_wr_i && sharp_amt_i < 0);
endmodule : pcp_checker

bind pcp_pipeline pcp_checker u_pcp_checker (.*);

// ---- bench/pcp_sensor_model.sv ----
module pcp_sensor_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic go_i,
  input wire logic [11:0] val_i,
  input wire logic [1:0] ch_i,
  input wire logic last_i,
  output logic [11:0] pix_o,
  output logic valid_o,
  output logic [1:0] chan_o,
  output logic frame_end_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic g, l;
  logic [11:0] v;
  logic [1:0] c;
  initial {pix_o, valid_o, chan_o, frame_end_o} = '0;
  // Idle data lines toggle so a stale pixel can never pass for a fresh one
  always @(posedge clk_i)
  begin
    {g, v, c, l} = {go_i, val_i, ch_i, last_i};
    #1;
    valid_o = g && nrst_i;
    frame_end_o = g && l && nrst_i;
    pix_o = g ? v : ~pix_o;
    chan_o = g ? c : ~chan_o;
  end
endmodule : pcp_sensor_model

// ---- bench/test_pcp_pipeline.sv ----
module test_pcp_pipeline;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, nrst_i, pix_valid_i, frame_end_i, gain_wr_i, ag_mode_wr_i, blk_wr_i, wb_wr_i;
  logic wb_sel_i, wb_mode_wr_i, preset_wr_i, power_curve_on_i, pixel_lookup_stage_on_i;
  logic lut_wr_i, sharp_en_wr_i, sharp_en_i, sharp_auto_i, sharp_amt_wr_i, pix_valid_o;
  logic sharp_en_o, go, last;
  logic [1:0] pix_chan_i, gain_sel_i, auto_amplification_mode_i, wb_mode_i, ch;
  logic [1:0] illuminant_preset_i, pix_chan_o, auto_amplification_mode_o, wb_mode_o, ccm_sel_o;
  logic [5:0] gain_db_i, gain_db_o;
  logic [8:0] blk_total_i, blk_analog_o, blk_digital_o, blk_total_o;
  logic [11:0] pix_i, lut_addr_i, lut_data_i, pix_o, wb_ratio_i, wb_red_o, wb_blue_o, val;
  logic [9:0] gamma_i;
  logic [7:0] sharp_thr_i, sharp_thr_o;
  logic signed [8:0] sharp_amt_i, sharp_amt_o;
  logic [31:0] seed = 32'hf2da;
  int bad_count, tests_run, gdb, bdig, rr, gam, lut, sen, sthr, nsent, loose, h0, h1, t1, me, mt;
  int eq[$], tq[$], cq[$], hc;

  pcp_pipeline u_pcp_pipeline (.*);
  pcp_sensor_model u_pcp_sensor_model (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(go), .val_i(val),
    .ch_i(ch), .last_i(last), .pix_o(pix_i), .valid_o(pix_valid_i), .chan_o(pix_chan_i),
    .frame_end_o(frame_end_i));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int sat(int x);
    return x < 0 ? 0 : (x > 4095 ? 4095 : x);
  endfunction : sat
  // Stages ahead of the sharpener; gamma is compared with a tolerance
  function automatic int xf(int p, int c);
    int s;
    s = sat(p * (gdb == 6 ? 2 : 1) + ((bdig * 4095 * 41) >> 14));
    if (c == 1) s = sat((s * rr) >> 8);
    if (gam != 0) s = sat($rtoi($pow(s / 4095.0, 0.453125) * 4095.0));
    return lut != 0 ? 4095 - s : s;
  endfunction : xf
  function automatic int sh(int l, int c, int r);
    int hd;
    hd = (2 * c - l - r) / 2;
    return (sen != 0 && (hd > sthr * 4095 / 256 || -hd > sthr * 4095 / 256)) ? sat(c + hd) : c;
  endfunction : sh
  function automatic logic [25:0] pre(int p);
    case (p)
      0: return {12'h180, 12'h1a0, 2'h0};
      1: return {12'h100, 12'h2c0, 2'h1};
      2: return {12'h140, 12'h200, 2'h2};
      default: return {12'h160, 12'h1c0, 2'h3};
    endcase
  endfunction : pre

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %0t got %0h expected %0h", $time, g, e);
    end
  endtask : chk
  task automatic send(input int v, input int c, input bit l);
    int t;
    {go, val, ch, last} = {1'b1, v[11:0], c[1:0], l};
    t = xf(v, c);
    if (nsent >= 2)
    begin
      eq.push_back(sh(h0, h1, t));
      tq.push_back(loose != 0 ? 4095 : t1 + sen);
      cq.push_back(hc);
    end
    {h0, h1, t1, hc} = {h1, t, gam != 0 ? 32'd200 : 32'd0, c};
    nsent++;
    tick();
  endtask : send
  task automatic cfg(input int g, input int b, input int r);
    {gain_db_i, blk_total_i, wb_sel_i, wb_ratio_i} = {g[5:0], b[8:0], 1'b0, r[11:0]};
    {gain_wr_i, blk_wr_i, wb_wr_i} = 3'h7;
    tick();
    {gain_wr_i, blk_wr_i, wb_sel_i, wb_ratio_i} = {3'h1, 12'h100};
    tick();
    wb_wr_i = 0;
    {gdb, bdig, rr} = {g, b > 40 ? b - 40 : 0, r};
  endtask : cfg
  task automatic shp(input bit e, input int t);
    {sharp_en_i, sharp_thr_i, sharp_amt_i} = {e, t[7:0], 9'sh010};
    {sharp_en_wr_i, sharp_amt_wr_i} = 2'h3;
    tick();
    {sharp_en_wr_i, sharp_amt_wr_i} = 2'h0;
    {sen, sthr} = {int'(e), t > 64 ? 32'd64 : t};
  endtask : shp
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  // Outputs are read 2 ns after the edge so the register updates have landed
  always @(posedge clk_i)
  begin
    #2;
    if (pix_valid_o === 1'b1 && eq.size() == 0)
    begin
      bad_count++;
      $display("BAD %0t pixel out of nowhere", $time);
    end
    else if (pix_valid_o === 1'b1)
    begin
      me = eq.pop_front();
      mt = tq.pop_front();
      chk(pix_chan_o, cq.pop_front());
      tests_run++;
      if ($isunknown(pix_o) || int'(pix_o) > me + mt || int'(pix_o) + mt < me)
      begin
        bad_count++;
        $display("BAD %0t pixel %0d expected %0d", $time, pix_o, me);
      end
    end
  end
  initial
  begin
    #200000;
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end

  initial
  begin
    logic [31:0] r;
    int a, v;
    {gain_wr_i, ag_mode_wr_i, blk_wr_i, wb_wr_i, wb_sel_i, wb_mode_wr_i, preset_wr_i} = '0;
    {power_curve_on_i, pixel_lookup_stage_on_i, lut_wr_i, sharp_en_wr_i, sharp_en_i} = '0;
    {sharp_auto_i, sharp_amt_wr_i, go, last, nrst_i, gain_sel_i, ch} = '0;
    {auto_amplification_mode_i, wb_mode_i, illuminant_preset_i, gain_db_i, blk_total_i} = '0;
    {wb_ratio_i, gamma_i, lut_addr_i, lut_data_i, sharp_thr_i, val} = {12'h100, 10'h080, 44'h0};
    sharp_amt_i = 9'sh010;
    rr = 256;
    repeat (10) @(posedge clk_i);
    #1 nrst_i = 1;
    chk(sharp_amt_o, 32'h0000_0020);
    chk(sharp_en_o, 0);
    chk({blk_total_o, gain_db_o}, 0);
    chk({wb_red_o, wb_blue_o}, {12'h100, 12'h100});
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      r = i < 2 ? {32{i == 0}} : rnd();
      {gain_db_i, blk_total_i, sharp_amt_i, sharp_thr_i} = {r[5:0], r[14:6], r[23:15], r[31:24]};
      {wb_sel_i, wb_ratio_i} = {r[3], 12'h010 + 12'(r[20:9] % 12'hfe0)};
      {gain_wr_i, blk_wr_i, sharp_amt_wr_i, wb_wr_i} = 4'hf;
      tick();
      {gain_wr_i, blk_wr_i, sharp_amt_wr_i, wb_wr_i} = 4'h0;
      a = r[14:6] > 400 ? 400 : r[14:6];
      v = $signed(r[23:15]);
      chk(gain_db_o, r[5:0] > 47 ? 47 : r[5:0]);
      chk({blk_analog_o, blk_digital_o}, {9'(a > 40 ? 40 : a), 9'(a > 40 ? a - 40 : 0)});
      chk(blk_total_o, a);
      chk(sharp_amt_o, v < -16 ? -16 : (v > 128 ? 128 : v));
      chk(sharp_thr_o, r[31:24] > 64 ? 64 : r[31:24]);
      chk(r[3] ? wb_blue_o : wb_red_o, wb_ratio_i);
    end
    $display("test settings done");
    for (int p = 0; p < 4; p++)
    begin
      {illuminant_preset_i, wb_sel_i, wb_ratio_i} = {p[1:0], 1'b0, 12'h333};
      {preset_wr_i, wb_wr_i} = 2'h3;
      tick();
      {preset_wr_i, wb_wr_i} = 2'h0;
      chk({wb_red_o, wb_blue_o, ccm_sel_o}, pre(p));
    end
    $display("test presets done");
    cfg(0, 0, 256);
    shp(0, 0);
    for (int k = 0; k < 4096; k++)
    begin
      {lut_addr_i, lut_data_i, lut_wr_i} = {k[11:0], 12'(4095 - k), 1'b1};
      tick();
    end
    lut_wr_i = 0;
    for (int s = 0; s < 8; s++)
    begin
      case (s)
        1: cfg(6, 0, 256);
        2: cfg(0, 80, 256);
        3: cfg(0, 0, 512);
        4: {power_curve_on_i, gamma_i, gam} = {1'b1, 10'h074, 32'd1};
        5: {pixel_lookup_stage_on_i, lut} = {1'b1, 32'd1};
        6: {power_curve_on_i, pixel_lookup_stage_on_i, gam, lut} = {2'h0, 64'h0};
        default: ;
      endcase
      if (s == 4) cfg(0, 0, 256);
      if (s >= 6) shp(1, s == 6 ? 0 : 8'hc0);
      for (int k = 0; k < 16; k++)
      begin
        r = rnd();
        loose = k < 2;
        v = s < 4 ? r[11:0] : (s < 6 ? 2048 + r[10:0] : 1000 + r[5:0]);
        if (s >= 6 && k % 2 == 1) v = k % 4 == 1 ? 3000 : 1200;
        send(v, k % 3, k == 15);
      end
      go = 0;
      repeat (8) tick();
      $display("test stream %0d done", s);
    end
    shp(0, 0);
    {loose, sharp_auto_i, auto_amplification_mode_i, ag_mode_wr_i} = {32'd1, 1'b1, 2'h1, 1'b1};
    tick();
    ag_mode_wr_i = 0;
    for (int k = 0; k < 4; k++) send(100, k % 3, k == 3);
    go = 0;
    repeat (6) tick();
    chk({gain_db_o, auto_amplification_mode_o}, {6'h01, 2'h0});
    {auto_amplification_mode_i, ag_mode_wr_i} = {2'h2, 1'b1};
    tick();
    {ag_mode_wr_i, gain_db_i, gain_wr_i} = {1'b0, 6'h0a, 1'b1};
    tick();
    gain_wr_i = 0;
    chk(gain_db_o, 1);
    {auto_amplification_mode_i, ag_mode_wr_i} = {2'h0, 1'b1};
    tick();
    ag_mode_wr_i = 0;
    $display("test gain auto done");
    {wb_mode_i, wb_mode_wr_i} = {2'h1, 1'b1};
    tick();
    wb_mode_wr_i = 0;
    for (int f = 0; f < 9; f++)
    begin
      send(1000, 0, 0);
      send(3000, 1, 0);
      send(1000, 2, 1);
      go = 0;
      repeat (6) tick();
    end
    chk({wb_mode_o, wb_red_o < 12'h100}, 3'h1);
    $display("test balance auto done");
    test_done();
  end
endmodule : test_pcp_pipeline
